// *** hdl/pc_stack_pkg.sv ***
// Constants and types for the program counter and return stack.
// Assumes one clock domain and a single fetch and execute core.
//
// Behaviour
// - Program counter is 21 bits in low, high and upper bytes, byte address.
// - Fetches above implemented memory inside the 2-Mbyte space return zeros.
// - Counter starts at zero after reset; interrupts vector to 0008h or 0018h.
// - Only the low byte is directly accessible; upper bits go through latches.
// - Writing the low byte loads high and upper bytes from the latches.
// - Reading the low byte copies high and upper bytes into the latches.
// - Counter bit 0 is always zero; sequential fetches advance by 2.
// - Calls, jumps and branches load their target and ignore the latches.
// - Stack is 31 words of 21 bits with a 5-bit pointer, outside memory.
// - Calls and interrupts push, returns pop; only an overflow reset disturbs the latches, clearing them.
// - Push increments the pointer first, then writes the counter there.
// - Pop loads the counter from the pointed entry, then decrements.
// - Reset sets the pointer to zero, an empty state with no entry.
// - Top entry registers show the pointed entry; writes update it.
// - Stack pointer holds 0 to 31 and is readable and writable.
// - Thirty-one pushes without a pop set the full flag; software clears it.
// - With overflow reset on, 31st push stores PC+2, sets full, resets.
// - With overflow reset off, pointer stops at 31 and no entry is overwritten.
// - Pop from empty loads zero, sets underflow, keeps pointer at zero.
// - Software push stores the counter; software pop only decrements.
// - Wake by interrupt with a global enable pushes the counter.

package pc_stack_pkg;

  // ----------------------------------------------------------------------
  // Widths and fixed values
  // ----------------------------------------------------------------------
  localparam int          PC_W        = 21;
  localparam int          PTR_W       = 5;
  localparam int          STACK_DEPTH = 31;
  localparam logic [20:0] VEC_RESET   = 21'h000000;
  localparam logic [20:0] VEC_HIGH    = 21'h000008;
  localparam logic [20:0] VEC_LOW     = 21'h000018;
  localparam logic [20:0] PC_STEP     = 21'h000002;
  localparam logic [4:0]  PTR_EMPTY   = 5'h00;
  localparam logic [4:0]  PTR_LAST    = 5'h1F;
  localparam logic [4:0]  PTR_PREV    = 5'h1E;
  localparam int          FULL_BIT    = 7;
  localparam int          UNF_BIT     = 6;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [2:0] OFS_LOW      = 3'h0;
  localparam logic [2:0] OFS_HLATCH   = 3'h1;
  localparam logic [2:0] OFS_ULATCH   = 3'h2;
  localparam logic [2:0] OFS_PTR      = 3'h3;
  localparam logic [2:0] OFS_TOP_LOW  = 3'h4;
  localparam logic [2:0] OFS_TOP_HIGH = 3'h5;
  localparam logic [2:0] OFS_TOP_UP   = 3'h6;

  // ----------------------------------------------------------------------
  // Core operations and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_SEQ  = 3'b001,
    OP_CALL = 3'b010,
    OP_JUMP = 3'b011,
    OP_RET  = 3'b100,
    OP_PUSH = 3'b101,
    OP_POP  = 3'b110,
    OP_IRQ  = 3'b111
  } core_op_t;

  typedef struct packed {
    core_op_t    op;
    logic [20:0] target;
    logic        low_prio;
  } core_req_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

// *** hdl/program_counter_return_stack.sv ***
// Program counter with latch registers and a 31-entry return stack.
// Assumes the core issues one operation per cycle and that the program
// memory answers fetch_data for fetch_addr within the same cycle.

`timescale 1ns/1ns

module program_counter_return_stack
  import pc_stack_pkg::*;
#(
  parameter logic [20:0] PMEM_BYTES = 21'h008000
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire core_req_t   core_req,
  input  wire logic        wake_irq,
  input  wire logic        high_priority_global_enable,
  input  wire logic        low_priority_global_enable,
  input  wire logic        overflow_reset_enable,
  input  wire logic [15:0] fetch_data,
  input  wire reg_req_t    reg_req,
  output logic [20:0]      fetch_addr,
  output logic [15:0]      instr_word,
  output logic [7:0]       rdata,
  output logic             stack_reset,
  output logic             stack_full_flag,
  output logic             stack_underflow_flag
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [20:0] pc_r;
  logic [7:0]  counter_high_latch_r;
  logic [4:0]  counter_upper_latch_r;
  logic [4:0]  ptr_r;
  logic        full_r;
  logic        unf_r;
  logic [7:0]  rdata_r;
  logic [15:0] instr_r;
  logic        stack_reset_r;
  logic [20:0] stack_mem [1:STACK_DEPTH];

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic        irq_take;
  logic        push_ev;
  logic        pop_ev;
  logic        swpop_ev;
  logic        ptr_zero;
  logic        push_ok;
  logic        fill_last;
  logic        ovf_rst;
  logic [20:0] push_val;
  logic [20:0] top_entry;
  logic [20:0] irq_vec;
  logic [4:0]  ptr_inc;
  logic        wr_low;
  logic        wr_ptr;

  assign irq_take = (core_req.op == OP_IRQ) ||
                    (wake_irq && (high_priority_global_enable ||
                                  low_priority_global_enable));
  assign push_ev  = (core_req.op == OP_CALL) ||
                    (core_req.op == OP_PUSH) || irq_take;
  assign pop_ev   = (core_req.op == OP_RET);
  assign swpop_ev = (core_req.op == OP_POP);
  assign ptr_zero = (ptr_r == PTR_EMPTY);
  assign ptr_inc  = ptr_r + 5'h01;
  assign push_ok  = push_ev && (ptr_r != PTR_LAST);
  assign fill_last = push_ok && (ptr_r == PTR_PREV);
  assign ovf_rst  = fill_last && overflow_reset_enable;
  assign push_val = ovf_rst ? pc_r + PC_STEP : pc_r;
  assign top_entry = ptr_zero ? VEC_RESET : stack_mem[ptr_r];
  assign irq_vec  = core_req.low_prio ? VEC_LOW : VEC_HIGH;
  assign wr_low   = reg_req.wr && (reg_req.addr == OFS_LOW);
  assign wr_ptr   = reg_req.wr && (reg_req.addr == OFS_PTR);

  // ----------------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pc_r <= VEC_RESET;
    end else if (ovf_rst) begin
      pc_r <= VEC_RESET;
    end else if (wr_low) begin
      pc_r <= {counter_upper_latch_r, counter_high_latch_r,
               reg_req.wdata[7:1], 1'b0};
    end else if (irq_take) begin
      pc_r <= irq_vec;
    end else begin
      case (core_req.op)
        OP_SEQ: begin
          pc_r <= pc_r + PC_STEP;
        end
        OP_CALL, OP_JUMP: begin
          pc_r <= {core_req.target[20:1], 1'b0};
        end
        OP_RET: begin
          pc_r <= {top_entry[20:1], 1'b0};
        end
        default: begin
          pc_r <= pc_r;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Latch registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      counter_high_latch_r  <= 8'h00;
      counter_upper_latch_r <= 5'h00;
    end else if (ovf_rst) begin
      counter_high_latch_r  <= 8'h00;
      counter_upper_latch_r <= 5'h00;
    end else if (reg_req.wr && reg_req.addr == OFS_HLATCH) begin
      counter_high_latch_r  <= reg_req.wdata;
    end else if (reg_req.wr && reg_req.addr == OFS_ULATCH) begin
      counter_upper_latch_r <= reg_req.wdata[4:0];
    end else if (reg_req.rd && reg_req.addr == OFS_LOW) begin
      counter_high_latch_r  <= pc_r[15:8];
      counter_upper_latch_r <= pc_r[20:16];
    end
  end

  // ----------------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ptr_r <= PTR_EMPTY;
    end else if (ovf_rst) begin
      ptr_r <= PTR_EMPTY;
    end else if (wr_ptr) begin
      ptr_r <= reg_req.wdata[4:0];
    end else if (push_ok) begin
      ptr_r <= ptr_inc;
    end else if ((pop_ev || swpop_ev) && !ptr_zero) begin
      ptr_r <= ptr_r - 5'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Full and underflow flags; a new event wins over a software clear.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      full_r <= 1'b0;
      unf_r  <= 1'b0;
    end else begin
      full_r <= fill_last || (push_ev && ptr_r == PTR_LAST) ||
                (full_r && !(wr_ptr && !reg_req.wdata[FULL_BIT]));
      unf_r  <= ((pop_ev || swpop_ev) && ptr_zero) ||
                (unf_r && !(wr_ptr && !reg_req.wdata[UNF_BIT]));
    end
  end

  // ----------------------------------------------------------------------
  // Stack storage; entry zero does not exist.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (push_ok) begin
      stack_mem[ptr_inc] <= push_val;
    end else if (reg_req.wr && !ptr_zero) begin
      case (reg_req.addr)
        OFS_TOP_LOW: begin
          stack_mem[ptr_r][7:0] <= reg_req.wdata;
        end
        OFS_TOP_HIGH: begin
          stack_mem[ptr_r][15:8] <= reg_req.wdata;
        end
        OFS_TOP_UP: begin
          stack_mem[ptr_r][20:16] <= reg_req.wdata[4:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register read port, data one cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        OFS_LOW:      rdata_r <= pc_r[7:0];
        OFS_PTR:      rdata_r <= {full_r, unf_r, 1'b0, ptr_r};
        OFS_TOP_LOW:  rdata_r <= top_entry[7:0];
        OFS_TOP_HIGH: rdata_r <= top_entry[15:8];
        OFS_TOP_UP:   rdata_r <= {3'h0, top_entry[20:16]};
        default:      rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Instruction fetch and overflow reset pulse
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      instr_r <= 16'h0000;
    end else if (pc_r < PMEM_BYTES) begin
      instr_r <= fetch_data;
    end else begin
      instr_r <= 16'h0000;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stack_reset_r <= 1'b0;
    end else begin
      stack_reset_r <= ovf_rst;
    end
  end

  assign fetch_addr           = pc_r;
  assign instr_word           = instr_r;
  assign rdata                = rdata_r;
  assign stack_reset          = stack_reset_r;
  assign stack_full_flag      = full_r;
  assign stack_underflow_flag = unf_r;

endmodule

// *** tb/pc_stack_checker.sv ***
// Port assertions for the program counter and return stack.
// Assumes a bind to the top module with the same memory size parameter.
`timescale 1ns/1ns
module pc_stack_checker
  import pc_stack_pkg::*;
#(
  parameter logic [20:0] PMEM_BYTES = 21'h008000
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire core_req_t   core_req,
  input wire logic        wake_irq,
  input wire logic        high_priority_global_enable,
  input wire logic        low_priority_global_enable,
  input wire logic        overflow_reset_enable,
  input wire logic [15:0] fetch_data,
  input wire reg_req_t    reg_req,
  input wire logic [20:0] fetch_addr,
  input wire logic [15:0] instr_word,
  input wire logic [7:0]  rdata,
  input wire logic        stack_reset,
  input wire logic        stack_full_flag,
  input wire logic        stack_underflow_flag
);
  logic irq;
  logic low_wr;
  logic ptr_wr;
  assign irq = core_req.op == OP_IRQ || wake_irq
    && (high_priority_global_enable || low_priority_global_enable);
  assign low_wr = reg_req.wr && reg_req.addr == OFS_LOW;
  assign ptr_wr = reg_req.wr && reg_req.addr == OFS_PTR;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_pc_even: assert property (fetch_addr[0] == 1'b0)
    else $error("odd fetch address");
  a_seq_step: assert property (core_req.op == OP_SEQ && !irq
    && !low_wr |=> fetch_addr == $past(fetch_addr) + PC_STEP)
    else $error("sequential step not two");
  a_jump_load: assert property (core_req.op == OP_JUMP && !irq
    && !low_wr |=> fetch_addr == ($past(core_req.target) & 21'h1FFFFE))
    else $error("jump target not loaded");
  a_irq_vector: assert property (irq && !low_wr |=> stack_reset
    || fetch_addr == ($past(core_req.low_prio) ? VEC_LOW : VEC_HIGH))
    else $error("wrong interrupt vector");
  a_fetch_word: assert property (1 |=> instr_word ==
    ($past(fetch_addr) < PMEM_BYTES ? $past(fetch_data) : 16'h0000))
    else $error("wrong instruction word");
  a_rdata_idle: assert property (!reg_req.rd |=> rdata == 8'h00)
    else $error("read data without read");
  a_low_write: assert property (low_wr |=> fetch_addr[7:0] ==
    ($past(reg_req.wdata) & 8'hFE)) else $error("low byte not loaded");
  a_full_kept: assert property (stack_full_flag && !ptr_wr
    |=> stack_full_flag) else $error("full flag dropped");
  a_unf_kept: assert property (stack_underflow_flag && !ptr_wr
    |=> stack_underflow_flag) else $error("underflow flag dropped");
  a_ovf_reset: assert property (stack_reset |-> stack_full_flag
    && fetch_addr == VEC_RESET ##1 !stack_reset)
    else $error("bad overflow reset");
  cover property (stack_reset);
  cover property ($rose(stack_underflow_flag));
  cover property (wake_irq && high_priority_global_enable);
endmodule

// *** tb/prog_mem_model.sv ***
// Program memory on the fetch side of the counter.
// Assumes a combinational answer for every fetch address.
`timescale 1ns/1ns
module prog_mem_model (
  input  wire logic [20:0] fetch_addr,
  output logic      [15:0] fetch_data
);
  // Neighbouring words differ, so a wrong fetch address shows.
  assign fetch_data = fetch_addr[16:1] ^ 16'h5A3C;
endmodule

// *** tb/program_counter_return_stack_tb.sv ***
// Self-checking bench for the program counter and return stack.
// Assumes the package, the design, the checker and the memory model.
`timescale 1ns/1ns
module program_counter_return_stack_tb
  import pc_stack_pkg::*;
;
  logic clk, reset, wake_irq, overflow_reset_enable, stack_reset;
  logic high_priority_global_enable, low_priority_global_enable;
  logic stack_full_flag, stack_underflow_flag;
  core_req_t   core_req;
  reg_req_t    reg_req;
  logic [20:0] fetch_addr;
  logic [15:0] fetch_data, instr_word;
  logic [7:0]  rdata, d;
  int          n_fail = 0, num_checks = 0, n_rst = 0;
  typedef struct packed {
    core_op_t    op;
    logic [20:0] tgt;
    logic        lp;
    logic [20:0] pc;
  } row_t;
  row_t rows [11] = '{
    '{OP_SEQ, 21'h000000, 1'b0, 21'h000002},
    '{OP_SEQ, 21'h000000, 1'b0, 21'h000004},
    '{OP_JUMP, 21'h001235, 1'b0, 21'h001234},
    '{OP_CALL, 21'h002001, 1'b0, 21'h002000},
    '{OP_SEQ, 21'h000000, 1'b0, 21'h002002},
    '{OP_IRQ, 21'h000000, 1'b0, 21'h000008},
    '{OP_RET, 21'h000000, 1'b0, 21'h002002},
    '{OP_IRQ, 21'h000000, 1'b1, 21'h000018},
    '{OP_RET, 21'h000000, 1'b0, 21'h002002},
    '{OP_RET, 21'h000000, 1'b0, 21'h001234},
    '{OP_JUMP, 21'h1FFFFF, 1'b0, 21'h1FFFFE}};
  program_counter_return_stack i_dut (.clk, .reset, .core_req, .wake_irq,
    .high_priority_global_enable, .low_priority_global_enable,
    .overflow_reset_enable, .fetch_data, .reg_req, .fetch_addr,
    .instr_word, .rdata, .stack_reset, .stack_full_flag,
    .stack_underflow_flag);
  prog_mem_model i_mem (.fetch_addr, .fetch_data);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (stack_reset === 1'b1) n_rst <= n_rst + 1;
  task automatic check(input logic [20:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic op_do(input core_op_t op, input logic [20:0] t);
    @(posedge clk) core_req <= '{op, t, 1'b0};
    @(posedge clk) core_req.op <= OP_NONE;
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk) reg_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk) reg_req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk) reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) reg_req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run;
  end
  initial begin
    reset = 1'b1;
    wake_irq = 1'b0;
    high_priority_global_enable = 1'b0;
    low_priority_global_enable = 1'b0;
    overflow_reset_enable = 1'b0;
    core_req = '0;
    reg_req = '0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    #1 check(fetch_addr, VEC_RESET);
    foreach (rows[i]) begin
      @(posedge clk) core_req <= '{rows[i].op, rows[i].tgt, rows[i].lp};
      @(posedge clk) core_req.op <= OP_NONE;
      #1 check(fetch_addr, rows[i].pc);
    end
    @(posedge clk);
    #1 check(instr_word, 16'h0000);
    $display("test core table finished");
    wr(OFS_HLATCH, 8'h3C);
    wr(OFS_ULATCH, 8'h05);
    wr(OFS_LOW, 8'h47);
    check(fetch_addr, 21'h053C46);
    op_do(OP_JUMP, 21'h000100);
    check(fetch_addr, 21'h000100);
    rd(OFS_LOW);
    check(d, 8'h00);
    wr(OFS_LOW, 8'h10);
    check(fetch_addr, 21'h000110);
    op_do(OP_CALL, 21'h004000);
    rd(OFS_TOP_HIGH);
    check(d, 8'h01);
    wr(OFS_TOP_LOW, 8'h20);
    op_do(OP_RET, 21'h000000);
    check(fetch_addr, 21'h000120);
    rd(OFS_PTR);
    check(d, 8'h00);
    op_do(OP_RET, 21'h000000);
    check(stack_underflow_flag, 1'b1);
    check(fetch_addr, VEC_RESET);
    wr(OFS_PTR, 8'h00);
    check(stack_underflow_flag, 1'b0);
    $display("test latches and top entry finished");
    op_do(OP_JUMP, 21'h000300);
    op_do(OP_PUSH, 21'h000000);
    op_do(OP_POP, 21'h000000);
    check(fetch_addr, 21'h000300);
    wr(OFS_PTR, 8'h01);
    rd(OFS_TOP_HIGH);
    check(d, 8'h03);
    @(posedge clk) wake_irq <= 1'b1;
    @(posedge clk) wake_irq <= 1'b0;
    #1 check(fetch_addr, 21'h000300);
    @(posedge clk) high_priority_global_enable <= 1'b1;
    wake_irq <= 1'b1;
    @(posedge clk) wake_irq <= 1'b0;
    high_priority_global_enable <= 1'b0;
    #1 check(fetch_addr, VEC_HIGH);
    rd(OFS_PTR);
    check(d, 8'h02);
    $display("test push, pop and wake finished");
    wr(OFS_PTR, 8'h1E);
    op_do(OP_PUSH, 21'h000000);
    op_do(OP_JUMP, 21'h000500);
    op_do(OP_PUSH, 21'h000000);
    rd(OFS_TOP_HIGH);
    check(d, 8'h00);
    rd(OFS_PTR);
    check(d, 8'h9F);
    wr(OFS_PTR, 8'h1E);
    overflow_reset_enable <= 1'b1;
    op_do(OP_CALL, 21'h000600);
    repeat (2) @(posedge clk);
    #1 check(fetch_addr, VEC_RESET);
    check(n_rst, 1);
    wr(OFS_PTR, 8'h9F);
    rd(OFS_TOP_LOW);
    check(d, 8'h02);
    @(posedge clk) reset <= 1'b1;
    @(posedge clk) reset <= 1'b0;
    #1 check(stack_full_flag, 1'b0);
    rd(OFS_PTR);
    check(d, 8'h00);
    $display("test overflow and reset finished");
    complete_run;
  end
endmodule
bind program_counter_return_stack pc_stack_checker #(
  .PMEM_BYTES(PMEM_BYTES)
) i_chk (.clk, .reset, .core_req, .wake_irq, .high_priority_global_enable,
  .low_priority_global_enable, .overflow_reset_enable, .fetch_data,
  .reg_req, .fetch_addr, .instr_word, .rdata, .stack_reset,
  .stack_full_flag, .stack_underflow_flag);
